// >>> uep_host.sv
`timescale 1ns/1ns
`include "uep_consts.svh"


module uep_host import uep_pkg::*; #(
  parameter int NUM_DEV = 1,
  parameter int DSEL_W = 1,
  parameter int ACCESS_NS = `UEP_ACCESS_NS,
  parameter int PULSE_CYC = (`UEP_PULSE_MS * `UEP_NS_PER_MS) / `UEP_CLK_NS,
  parameter int CNT_W = 20
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_CMD_VALID,
  input wire logic [1:0] I_CMD,
  input wire logic [`UEP_ADDR_W-1:0] I_ADDR,
  input wire logic [`UEP_DATA_W-1:0] I_WDATA,
  input wire logic [DSEL_W-1:0] I_DEV_SEL,
  output logic O_CMD_READY,
  output logic O_DONE,
  output logic [`UEP_DATA_W-1:0] O_RDATA,
  output logic O_VERIFY_OK,
  output logic [`UEP_ADDR_W-1:0] O_WORD_SELECT_LINES,
  output logic [NUM_DEV-1:0] O_SELECT_N,
  output logic O_GATE_N,
  output logic O_VPP_EN,
  input wire logic [`UEP_DATA_W-1:0] I_BYTE_OUTPUTS,
  output logic [`UEP_DATA_W-1:0] O_BYTE_OUTPUTS,
  output logic O_BYTE_OUTPUTS_OE
);

  // Dwell counts derived from the printed times
  localparam int ACC_CYC = `UEP_CEIL_CYC(ACCESS_NS);
  localparam int REL_CYC = `UEP_CEIL_CYC(`UEP_RELEASE_NS);
  localparam int DV_CYC = `UEP_CEIL_CYC(`UEP_VERIFY_US * `UEP_NS_PER_US);
  localparam int SETUP_CYC = `UEP_CEIL_CYC(`UEP_SETUP_US * `UEP_NS_PER_US);
  localparam int HOLD_CYC = `UEP_CEIL_CYC(`UEP_HOLD_US * `UEP_NS_PER_US);
  localparam int REC_CYC = `UEP_CEIL_CYC(`UEP_RECOVERY_US * `UEP_NS_PER_US);

  // Refuse settings the counters and the device select width cannot serve
  if (PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W)) begin : g_bad_pulse
    $error("PULSE_CYC does not fit the timer");
  end
  if (NUM_DEV < 1 || NUM_DEV > (1 << DSEL_W)) begin : g_bad_dev
    $error("NUM_DEV does not fit DSEL_W");
  end
  if (ACCESS_NS < 1 || ACC_CYC + `UEP_SYNC_CYC > 250) begin : g_bad_acc
    $error("ACCESS_NS out of range");
  end

  function automatic logic [CNT_W-1:0] dwell(input int cyc);
    return CNT_W'(cyc - 1);
  endfunction

  uep_state_t state_reg;
  uep_state_t state_next;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_zero;
  logic take;
  logic cmd_legal;
  logic samp;
  logic [`UEP_ADDR_W-1:0] addr_reg;
  logic [`UEP_DATA_W-1:0] wdata_reg;
  logic [DSEL_W-1:0] dev_reg;
  logic [`UEP_ADDR_W-1:0] cur_addr;
  logic [`UEP_DATA_W-1:0] cur_wdata;
  logic [DSEL_W-1:0] cur_dev;
  logic [`UEP_DATA_W-1:0] din_s1_reg;
  logic [`UEP_DATA_W-1:0] din_s2_reg;

  uep_timer #(.CNT_W(CNT_W)) u_timer (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_load(tmr_load),
    .i_load_val(tmr_val),
    .o_zero(tmr_zero)
  );

  // Command acceptance; reserved code and absent devices dropped silently
  // Without the device check the shared strobe could fall with no select low
  assign cmd_legal = ((I_CMD == CMD_READ) || (I_CMD == CMD_PROGRAM) || (I_CMD == CMD_VERIFY)) &&
                     (int'(I_DEV_SEL) < NUM_DEV);
  assign take = I_CMD_VALID && O_CMD_READY && cmd_legal;
  assign cur_addr = take ? I_ADDR : addr_reg;
  assign cur_wdata = take ? I_WDATA : wdata_reg;
  assign cur_dev = take ? I_DEV_SEL : dev_reg;
  assign samp = tmr_zero && (state_reg == ST_READ_ACC || state_reg == ST_VFY_ACC);

  // Sequencer next state and timer loads
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_reg)
      ST_IDLE: begin
        if (take) begin
          tmr_load = 1'b1;
          if (I_CMD == CMD_READ) begin
            state_next = ST_READ_ACC;
            tmr_val = dwell(ACC_CYC + `UEP_SYNC_CYC);
          end else if (I_CMD == CMD_PROGRAM) begin
            state_next = ST_PRG_SET;
            tmr_val = dwell(SETUP_CYC);
          end else begin
            state_next = ST_VFY_ACC;
            tmr_val = dwell(DV_CYC + `UEP_SYNC_CYC);
          end
        end
      end
      ST_READ_ACC, ST_VFY_ACC: begin
        if (tmr_zero) begin
          state_next = ST_RELEASE;
          tmr_load = 1'b1;
          tmr_val = dwell(REL_CYC);
        end
      end
      ST_PRG_SET: begin
        if (tmr_zero) begin
          state_next = ST_PRG_PLS;
          tmr_load = 1'b1;
          tmr_val = dwell(PULSE_CYC);
        end
      end
      ST_PRG_PLS: begin
        if (tmr_zero) begin
          state_next = ST_PRG_HOLD;
          tmr_load = 1'b1;
          tmr_val = dwell(HOLD_CYC);
        end
      end
      ST_PRG_HOLD: begin
        if (tmr_zero) begin
          state_next = ST_PRG_REC;
          tmr_load = 1'b1;
          tmr_val = dwell(REC_CYC);
        end
      end
      ST_PRG_REC: begin
        if (tmr_zero) begin
          state_next = ST_VFY_ACC;
          tmr_load = 1'b1;
          tmr_val = dwell(DV_CYC + `UEP_SYNC_CYC);
        end
      end
      ST_RELEASE: begin
        if (tmr_zero) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Request capture, held for the whole access
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      dev_reg <= '0;
    end else if (take) begin
      addr_reg <= I_ADDR;
      wdata_reg <= I_WDATA;
      dev_reg <= I_DEV_SEL;
    end
  end

  // Pin drive follows the next state so pins and state change together
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_SELECT_N <= '1;
      O_GATE_N <= 1'b1;
      O_VPP_EN <= 1'b0;
      O_BYTE_OUTPUTS_OE <= 1'b0;
      O_BYTE_OUTPUTS <= '0;
      O_WORD_SELECT_LINES <= '0;
      O_CMD_READY <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_DEV; i++) begin
        // Only the addressed device leaves standby; others stay inhibited
        O_SELECT_N[i] <= !(cur_dev == DSEL_W'(i) && (state_next == ST_READ_ACC ||
                           state_next == ST_VFY_ACC || state_next == ST_PRG_PLS));
      end
      // Shared strobe low only for read and verify
      O_GATE_N <= !(state_next == ST_READ_ACC || state_next == ST_VFY_ACC);
      // High voltage spans setup, pulse and hold only
      O_VPP_EN <= (state_next == ST_PRG_SET || state_next == ST_PRG_PLS || state_next == ST_PRG_HOLD);
      // Drive data only while the device output gate is high, so no contention
      O_BYTE_OUTPUTS_OE <= (state_next == ST_PRG_SET || state_next == ST_PRG_PLS ||
                            state_next == ST_PRG_HOLD);
      O_BYTE_OUTPUTS <= cur_wdata;
      O_WORD_SELECT_LINES <= cur_addr;
      O_CMD_READY <= (state_next == ST_IDLE);
    end
  end

  // Data pins come from outside the clock domain
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
    end else begin
      din_s1_reg <= I_BYTE_OUTPUTS;
      din_s2_reg <= din_s1_reg;
    end
  end

  // Results; verify compares with the captured byte
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_RDATA <= '0;
      O_VERIFY_OK <= 1'b0;
      O_DONE <= 1'b0;
    end else begin
      O_DONE <= (state_reg == ST_RELEASE) && tmr_zero;
      if (samp) begin
        O_RDATA <= din_s2_reg;
      end
      if (samp && state_reg == ST_VFY_ACC) begin
        O_VERIFY_OK <= (din_s2_reg == wdata_reg);
      end
    end
  end

  // Helper counters read only by the checks below
  logic any_sel;
  logic [CNT_W-1:0] pulse_cnt;
  logic [7:0] low_cnt;
  assign any_sel = ~&O_SELECT_N;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      pulse_cnt <= '0;
      low_cnt <= '0;
    end else begin
      pulse_cnt <= (any_sel && O_VPP_EN) ? pulse_cnt + 1'b1 : '0;
      if (any_sel && !O_GATE_N) begin
        low_cnt <= (low_cnt == 8'hFF) ? low_cnt : low_cnt + 1'b1;
      end else begin
        low_cnt <= '0;
      end
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  property p_vpp_gate_high;
    O_VPP_EN |-> O_GATE_N;
  endproperty
  a_vpp_gate_high: assert property (p_vpp_gate_high) else $error("gate low with high voltage");

  property p_one_select;
    $onehot0(~O_SELECT_N);
  endproperty
  a_one_select: assert property (p_one_select) else $error("more than one device selected");

  property p_gate_with_select;
    !O_GATE_N |-> any_sel;
  endproperty
  a_gate_with_select: assert property (p_gate_with_select) else $error("strobe without a selected device");

  property p_pulse_width;
    $rose(&O_SELECT_N) && O_VPP_EN |-> pulse_cnt == PULSE_CYC;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("program pulse width wrong");

  property p_no_steady;
    pulse_cnt <= PULSE_CYC;
  endproperty
  a_no_steady: assert property (p_no_steady) else $error("program pulse held too long");

  property p_verify_wait;
    samp && state_reg == ST_VFY_ACC |-> low_cnt >= DV_CYC;
  endproperty
  a_verify_wait: assert property (p_verify_wait) else $error("verify sampled too early");

  property p_verify_pins;
    state_reg == ST_VFY_ACC |-> !O_GATE_N && !O_VPP_EN && any_sel;
  endproperty
  a_verify_pins: assert property (p_verify_pins) else $error("verify pins wrong");

  property p_read_wait;
    samp && state_reg == ST_READ_ACC |-> low_cnt >= ACC_CYC;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read sampled too early");

  property p_release_gap;
    $rose(O_GATE_N) |-> (!O_BYTE_OUTPUTS_OE && !O_VPP_EN) [*2];
  endproperty
  a_release_gap: assert property (p_release_gap) else $error("bus driven before release");

  property p_setup_before_pulse;
    $fell(&O_SELECT_N) && O_VPP_EN |-> $past(O_BYTE_OUTPUTS_OE, SETUP_CYC);
  endproperty
  a_setup_before_pulse: assert property (p_setup_before_pulse) else $error("data setup too short");

  c_read: cover property (samp && state_reg == ST_READ_ACC);
  c_program: cover property ($rose(&O_SELECT_N) && O_VPP_EN);
  c_verify_ok: cover property ($rose(O_DONE) && O_VERIFY_OK);
  c_verify_bad: cover property (samp && state_reg == ST_VFY_ACC && din_s2_reg != wdata_reg);

endmodule

// >>> uep_consts.svh
`ifndef UEP_CONSTS_SVH
`define UEP_CONSTS_SVH

// Bus widths of the memory port
`define UEP_ADDR_W 12
`define UEP_DATA_W 8

// Controller clock period
`define UEP_CLK_NS 100

// Device timing, each in its own unit
`define UEP_ACCESS_NS 550
`define UEP_RELEASE_NS 130
`define UEP_VERIFY_US 1
`define UEP_SETUP_US 2
`define UEP_HOLD_US 2
`define UEP_RECOVERY_US 2
`define UEP_PULSE_MS 50

// Unit scales and extra cycles for the two-stage data synchroniser
`define UEP_NS_PER_US 1000
`define UEP_NS_PER_MS 1000000
`define UEP_SYNC_CYC 3

// Least time in ns to whole clock cycles, rounded up
`define UEP_CEIL_CYC(ns) (((ns) + `UEP_CLK_NS - 1) / `UEP_CLK_NS)

`endif

// >>> uep_pkg.sv
package uep_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_READ_ACC = 4'h1,
    ST_PRG_SET  = 4'h2,
    ST_PRG_PLS  = 4'h3,
    ST_PRG_HOLD = 4'h4,
    ST_PRG_REC  = 4'h5,
    ST_VFY_ACC  = 4'h6,
    ST_RELEASE  = 4'h7
  } uep_state_t;

  // User commands
  typedef enum logic [1:0] {
    CMD_READ    = 2'h0,
    CMD_PROGRAM = 2'h1,
    CMD_VERIFY  = 2'h2
  } uep_cmd_t;

endpackage

// >>> uep_timer.sv
`timescale 1ns/1ns
`include "uep_consts.svh"

module uep_timer import uep_pkg::*; #(
  parameter int CNT_W = 20
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_load_val,
  output logic o_zero
);

  logic [CNT_W-1:0] cnt_reg;

  // Down counter; a load of N-1 gives a dwell of N cycles
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_load_val;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign o_zero = (cnt_reg == '0);

endmodule

// >>> uep_dev_model.sv
`timescale 1ns/1ns
`include "uep_consts.svh"

// Behavioural memory; early sampling sees inverted data
module uep_dev_model #(
  parameter int ACC_NS = 550,
  parameter int GATE_NS = 150,
  parameter int VFY_NS = 1000
) (
  input wire logic [`UEP_ADDR_W-1:0] i_addr,
  input wire logic i_select_n,
  input wire logic i_gate_n,
  input wire logic i_vpp_en,
  input wire logic [`UEP_DATA_W-1:0] i_bus,
  output logic [`UEP_DATA_W-1:0] o_data,
  output logic o_drive,
  output int o_pulse_ns,
  output int o_pulse_cnt,
  output int o_fault_cnt
);
  logic [`UEP_DATA_W-1:0] mem_reg [0:4095];
  time t_sel, t_gate, t_addr, t_fall;
  logic vfy_pend;
  int sel_ns;

  // Erased state is all ones
  initial begin
    for (int i = 0; i < 4096; i++) mem_reg[i] = 8'hFF;
    {t_sel, t_gate, t_addr, t_fall} = '0;
    {vfy_pend, o_drive, o_data} = '0;
    {o_pulse_ns, o_pulse_cnt, o_fault_cnt} = '0;
  end

  // Edge times
  always @(i_addr) t_addr = $time;
  always @(negedge i_gate_n) t_gate = $time;
  always @(negedge i_select_n) begin
    t_sel = $time;
    if (i_vpp_en) t_fall = $time;
  end

  // Pulse end programs zeros only; unselected parts see no edge
  always @(posedge i_select_n) begin
    if (i_vpp_en) begin
      mem_reg[i_addr] = mem_reg[i_addr] & i_bus;
      o_pulse_ns = $time - t_fall;
      o_pulse_cnt++;
      vfy_pend = 1'b1;
    end else vfy_pend = 1'b0;
  end

  // Gate held low at programming voltage is impossible on one pin
  always @(i_vpp_en or i_gate_n) if (i_vpp_en && !i_gate_n) o_fault_cnt++;

  // Output stage polled every 10 ns; release is immediate, the harshest case
  always #10 begin
    o_drive = !i_select_n && !i_gate_n && !i_vpp_en;
    sel_ns = vfy_pend ? VFY_NS : ACC_NS;
    if ($time >= t_sel + sel_ns && $time >= t_gate + GATE_NS && $time >= t_addr + ACC_NS)
      o_data = mem_reg[i_addr];
    else o_data = ~mem_reg[i_addr];
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
`include "uep_consts.svh"

module tb_top;
  import uep_pkg::*;
  logic clk, rst, valid, dsel, oe, gate_n, vpp, ready, done, vok;
  logic [1:0] cmd, sel_n;
  logic [11:0] addr, wsl;
  logic [7:0] wdata, rdata, hdata, bus, idle_reg, d0, d1;
  logic dr0, dr1;
  int n_mismatch, tests_run, cyc_cnt, pw0, pw1, pc0, pc1, f0, f1, cyc;

  uep_host #(.NUM_DEV(2), .DSEL_W(1), .PULSE_CYC(40)) dut (.I_SYS_CLK(clk), .I_RESET(rst),
    .I_CMD_VALID(valid), .I_CMD(cmd), .I_ADDR(addr), .I_WDATA(wdata), .I_DEV_SEL(dsel),
    .O_CMD_READY(ready), .O_DONE(done), .O_RDATA(rdata), .O_VERIFY_OK(vok),
    .O_WORD_SELECT_LINES(wsl), .O_SELECT_N(sel_n), .O_GATE_N(gate_n), .O_VPP_EN(vpp),
    .I_BYTE_OUTPUTS(bus), .O_BYTE_OUTPUTS(hdata), .O_BYTE_OUTPUTS_OE(oe));
  uep_dev_model dev0 (.i_addr(wsl), .i_select_n(sel_n[0]), .i_gate_n(gate_n), .i_vpp_en(vpp),
    .i_bus(bus), .o_data(d0), .o_drive(dr0), .o_pulse_ns(pw0), .o_pulse_cnt(pc0), .o_fault_cnt(f0));
  uep_dev_model dev1 (.i_addr(wsl), .i_select_n(sel_n[1]), .i_gate_n(gate_n), .i_vpp_en(vpp),
    .i_bus(bus), .o_data(d1), .o_drive(dr1), .o_pulse_ns(pw1), .o_pulse_cnt(pc1), .o_fault_cnt(f1));

  // Undriven bus has no pull, so it toggles each cycle
  assign bus = oe ? hdata : dr0 ? d0 : dr1 ? d1 : idle_reg;
  always #50 clk = ~clk;
  always @(posedge clk) idle_reg <= ~idle_reg;

  task automatic stop_test;
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Hang guard, far above the whole sequence
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Pin watch: one select at a time, no contention, gate high at 25V
  always @(negedge clk) if (!rst) begin
    if (sel_n === 2'b00) chk("two selects", 12'h0, 12'h1);
    if (oe === 1'b1 && (dr0 || dr1)) chk("contention", 12'h0, 12'h1);
    if (vpp === 1'b1 && gate_n !== 1'b1) chk("gate at vpp", 12'h1, 12'h0);
  end

  // One command, waits for its done pulse under a bound
  task automatic run_cmd(input logic [1:0] c, input logic d, input logic [11:0] a,
                         input logic [7:0] w, input int lim);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    // A ready that never comes counts as a mismatch
    chk("ready", 12'h1, {11'h0, ready});
    {valid, cmd, dsel, addr, wdata} = {1'b1, c, d, a, w};
    @(negedge clk);
    valid = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < lim) begin
      @(negedge clk);
      cyc++;
    end
    if (lim > 50) chk("done", 12'h1, {11'h0, done});
    if (lim > 50) chk("ready at done", 12'h1, {11'h0, ready});
  endtask

  task automatic t_read(input logic d, input logic [11:0] a, input logic [7:0] exp);
    run_cmd(2'h0, d, a, 8'h00, 400);
    chk("address pins", a, wsl);
    chk("read data", {4'h0, exp}, {4'h0, rdata});
    @(negedge clk);
    chk("idle pins", 12'h00E, {8'h0, sel_n, gate_n, oe});
  endtask

  task automatic t_program;
    run_cmd(2'h1, 1'b1, 12'h123, 8'hA5, 400);
    chk("verify ok", 12'h1, {11'h0, vok});
    chk("verify data", 12'h0A5, {4'h0, rdata});
    chk("pulse count", 12'h1, pc1[11:0]);
    chk("pulse width", 12'hFA0, pw1[11:0]);
    chk("inhibited count", 12'h0, pc0[11:0]);
    t_read(1'b0, 12'h123, 8'hFF);
    t_read(1'b1, 12'h123, 8'hA5);
  endtask

  task automatic t_reprogram;
    run_cmd(2'h1, 1'b1, 12'h123, 8'h5A, 400);
    chk("reprogram ok", 12'h0, {11'h0, vok});
    chk("reprogram data", 12'h000, {4'h0, rdata});
  endtask

  task automatic t_verify;
    run_cmd(2'h2, 1'b1, 12'h123, 8'h00, 400);
    chk("verify match", 12'h1, {11'h0, vok});
    run_cmd(2'h2, 1'b1, 12'h123, 8'hFF, 400);
    chk("verify miss", 12'h0, {11'h0, vok});
  endtask

  task automatic t_top_addr;
    run_cmd(2'h1, 1'b0, 12'hFFF, 8'h3C, 400);
    chk("top verify", 12'h1, {11'h0, vok});
    t_read(1'b0, 12'hFFF, 8'h3C);
    t_read(1'b0, 12'h000, 8'hFF);
  endtask

  task automatic t_bad_code;
    run_cmd(2'h3, 1'b0, 12'h001, 8'h00, 30);
    chk("code 3 done", 12'h0, {11'h0, done});
    chk("code 3 pins", 12'h007, {9'h0, sel_n, gate_n});
    chk("model faults", 12'h0, f0[11:0] + f1[11:0]);
  endtask

  initial begin
    {clk, valid, dsel, cmd, addr, wdata, n_mismatch, tests_run, cyc_cnt} = '0;
    rst = 1'b1;
    idle_reg = 8'h5A;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk("reset pins", 12'h01C, {7'h0, sel_n, gate_n, vpp, oe});
    t_read(1'b0, 12'h0FF, 8'hFF);
    t_program();
    t_reprogram();
    t_verify();
    t_top_addr();
    t_bad_code();
    stop_test();
  end
endmodule
